/* File: epb_bank_dec.sv */
// Bank decoder: core address to active-low bank selects and bank offset
`timescale 1ns/1ps
module epb_bank_dec #(
    parameter int AW = epb_pkg::CORE_AW
) (
    input  wire logic [AW-1:0]             addr,
    input  wire logic [epb_pkg::NBANK-1:0] sdmap,
    output logic      [epb_pkg::NBANK-1:0] sel_n,
    output logic      [25:0]               offset,
    output logic                           hit
);

    logic [AW:0] base;
    logic [AW:0] size;
    logic [AW:0] rel;

    // ****************************************************************
    // Banks sit back to back; each spans its fixed size
    // ****************************************************************
    // Walk the banks in order so mixed sizes stack without holes
    always_comb begin
        base   = '0;
        size   = '0;
        rel    = '0;
        sel_n  = '1;
        offset = '0;
        hit    = 1'b0;
        for (int i = 0; i < epb_pkg::NBANK; i++) begin
            size = sdmap[i] ? ((AW+1)'(1) << epb_pkg::BANK_LOG_SD)
                            : ((AW+1)'(1) << epb_pkg::BANK_LOG_NS);
            if (!hit && ({1'b0, addr} >= base) && ({1'b0, addr} < base + size)) begin
                rel      = {1'b0, addr} - base;
                sel_n[i] = 1'b0;
                offset   = rel[25:0];
                hit      = 1'b1;
            end
            base = base + size;
        end
    end

endmodule : epb_bank_dec

/* File: epb_mem_model.sv */
// Behavioural external memory with programmable wait states
`timescale 1ns/1ps
module epb_mem_model (
    input  wire logic        clk,
    input  wire logic [23:0] addr,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [1:0]  waits,
    output logic             ack,
    output logic [47:0]      dq
);
    logic [1:0] cnt = 2'h0;
    // Count strobe cycles so a slow part can be mimicked
    always @(posedge clk) cnt <= (rd_n && wr_n) ? 2'h0 : cnt + 2'h1;
    assign ack = cnt >= waits;
    // A released bus shows the inverse, so stale data cannot pass
    assign dq = rd_n ? ~{8'h5a, addr, addr[15:0]} : {8'h5a, addr, addr[15:0]};
endmodule : epb_mem_model

/* File: epb_pkg.sv */
// Shared constants, carrier structs and state types of the external port bus interface
package epb_pkg;

    // ****************************************************************
    // Register map of the plain configuration port
    // ****************************************************************
    localparam logic [7:0]  REG_CFG      = 8'h00; // system_config_reg
    localparam logic [7:0]  REG_STAT     = 8'h04; // Status, read only except miss clear
    localparam logic [7:0]  REG_SADDR    = 8'h08; // Last decoded slave address

    // Field positions inside system_config_reg and the status register
    localparam int          CFG_IPACK_LSB = 0;    // instr_packing_field, 2 bits
    localparam int          CFG_SYNC_BIT  = 2;    // 1 = synchronous select timing
    localparam int          CFG_LINK0_BIT = 3;    // First link port owns the low lane
    localparam int          CFG_LINK1_BIT = 4;    // Second link port owns the mid lane
    localparam int          CFG_HALF_BIT  = 5;    // SDRAM at half rate
    localparam int          CFG_SDMAP_LSB = 8;    // One bit per bank: bank is SDRAM
    localparam int          STAT_MISS_BIT = 0;    // Sticky refused access, write 1 clears

    // Field values and size figures
    localparam logic [1:0]  IPACK_NOPACK  = 2'h1; // Full width, no packing
    localparam logic [1:0]  ID_KEEP_HI    = 2'h0; // Identity 00x enables the keepers
    localparam int          BANK_LOG_NS   = 24;   // 16 M words per non-SDRAM bank
    localparam int          BANK_LOG_SD   = 26;   // 64 M words per SDRAM bank
    localparam int          IOP_LOG_DEF   = 9;    // Size of the slave register window
    localparam int          NBANK         = 4;
    localparam int          CORE_AW       = 28;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        EPB_IDLE = 2'b00,
        EPB_ACC  = 2'b01,
        EPB_TURN = 2'b10
    } epb_state_t;

    // Master access request from the core
    typedef struct packed {
        logic                we;
        logic                fetch;
        logic [CORE_AW-1:0]  addr;
        logic [47:0]         wdata;
    } epb_req_t;

    // Slave access toward the register file of the core
    typedef struct packed {
        logic                rd;
        logic                wr;
        logic [23:0]         addr;
        logic [31:0]         wdata;
    } epb_slv_t;

    // Whole state of the top module
    typedef struct packed {
        epb_state_t          st;
        logic                step;
        logic                we;
        logic                sd;
        logic                wide;
        logic [1:0]          ipack;
        logic                sync;
        logic                link0_en;
        logic                link1_en;
        logic                half;
        logic [NBANK-1:0]    sdmap;
        logic                keep_cap;
        logic                keep_en;
        logic                miss;
        logic                busy;
        logic                done;
        logic [47:0]         rdata;
        logic [23:0]         addr_o;
        logic                addr_oe;
        logic [NBANK-1:0]    ms_o;
        logic                ms_oe;
        logic                rd_o;
        logic                wr_o;
        logic                strb_oe;
        logic [47:0]         wd;
        logic                dat_oe;
        logic [7:0]          mid_o;
        logic                mid_oe;
        logic [7:0]          low_o;
        logic                low_oe;
        logic [7:0]          l0_din;
        logic [7:0]          l1_din;
        logic                slv_rd_q;
        logic                slv_wr_q;
        epb_slv_t            slv;
        logic [NBANK-1:0]    ms_seen;
        logic [31:0]         reg_rdata;
    } epb_st_t;

    localparam epb_st_t ST_RST = '{st: EPB_IDLE, rd_o: 1'b1, wr_o: 1'b1,
                                   ms_o: 4'hf, ms_seen: 4'hf, default: '0};

endpackage : epb_pkg

/* File: epb_top.sv */
// External port bus interface: master accesses, slave register decode, lanes
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps

// Contract
// - As master, drive the target address on the external address bus.
// - As slave, take the address bus as input and decode it.
// - Peers reach only the slave register window; other memory only via DMA.
// - Identity 00x enables the pin keepers; other identities disable them.
// - Upper data lanes carry data words and instruction fetches both ways.
// - Mid and low lanes extend the bus only when their link port is off.
// - Packing field 0x1 fetches whole 48-bit instructions over the wide bus.
// - Non-SDRAM fetch at system rate; SDRAM at full or half rate.
// - Decode upper address into four active-low selects, only one asserted.
// - Banks span 16 M words non-SDRAM, 64M words SDRAM.
// - Asynchronous mode: selects change together with the address.
// - Synchronous mode: select drops after first cycle with acknowledge sampled high.
// - As slave, monitor the bank selects of the current master.
// - As master, pull the read strobe low for every word read.
// - As master, pull the write strobe low for every word written.
module epb_top #(
    parameter int IOP_LOG = epb_pkg::IOP_LOG_DEF
) (
    input  wire logic                           clk,
    input  wire logic                           rstn,
    // Configuration port
    input  wire logic [7:0]                     reg_addr,
    input  wire logic [31:0]                    reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [31:0]                    reg_rdata,
    // Core side
    input  wire logic                           bus_master,
    input  wire logic                           core_req,
    input  wire epb_pkg::epb_req_t              core_cmd,
    output logic                                core_busy,
    output logic                                core_done,
    output logic      [47:0]                    core_rdata,
    output epb_pkg::epb_slv_t                   io_processor_regs,
    input  wire logic [31:0]                    iop_rdata,
    // Link ports sharing the low data lanes
    input  wire logic [7:0]                     first_link_dout,
    input  wire logic                           first_link_doe,
    output logic      [7:0]                     first_link_data,
    input  wire logic [7:0]                     second_link_dout,
    input  wire logic                           second_link_doe,
    output logic      [7:0]                     second_link_data,
    // External pins
    input  wire logic [2:0]                     proc_identity_pins,
    output logic                                keeper_en,
    input  wire logic [23:0]                    ext_addr_bus_i,
    output logic      [23:0]                    ext_addr_bus_o,
    output logic                                ext_addr_bus_oe,
    input  wire logic [31:0]                    ext_data_bus_upper_i,
    output logic      [31:0]                    ext_data_bus_upper_o,
    output logic                                ext_data_bus_upper_oe,
    input  wire logic [7:0]                     ext_data_lane_mid_i,
    output logic      [7:0]                     ext_data_lane_mid_o,
    output logic                                ext_data_lane_mid_oe,
    input  wire logic [7:0]                     ext_data_lane_low_i,
    output logic      [7:0]                     ext_data_lane_low_o,
    output logic                                ext_data_lane_low_oe,
    input  wire logic [epb_pkg::NBANK-1:0]      bank_select_n_i,
    output logic      [epb_pkg::NBANK-1:0]      bank_select_n_o,
    output logic                                bank_select_n_oe,
    input  wire logic                           rd_n_i,
    output logic                                rd_n_o,
    output logic                                rd_n_oe,
    input  wire logic                           wr_n_i,
    output logic                                wr_n_o,
    output logic                                wr_n_oe,
    input  wire logic                           ack_i
);

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic [1:0]          rst_q;
    logic                rst_sn;

    // Two flops so release never lands mid-edge in the state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_sn = rst_q[1];

    // ****************************************************************
    // Bank decode
    // ****************************************************************
    epb_pkg::epb_st_t s;
    epb_pkg::epb_st_t n;
    logic [epb_pkg::NBANK-1:0] dec_sel_n;
    logic [25:0]               dec_off;
    logic                      dec_hit;

    epb_bank_dec #(
        .AW     (epb_pkg::CORE_AW)
    ) u_dec (
        .addr   (core_cmd.addr),
        .sdmap  (s.sdmap),
        .sel_n  (dec_sel_n),
        .offset (dec_off),
        .hit    (dec_hit)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic             go;
    logic             take;
    logic             wide_ok;
    logic             iop_hit;
    logic             finish;

    // Half-rate SDRAM steps on every other cycle; everything else every cycle
    assign go      = !(s.sd && s.half) || s.step;
    assign take    = (s.st == epb_pkg::EPB_IDLE) && core_req && bus_master;
    assign wide_ok = (s.ipack == epb_pkg::IPACK_NOPACK) && !s.link0_en && !s.link1_en;
    assign iop_hit = (ext_addr_bus_i >> IOP_LOG) == 24'h0;
    assign finish  = (s.st == epb_pkg::EPB_ACC) && go && ack_i;

    always_comb begin
        n           = s;
        n.done      = 1'b0;
        n.slv.rd    = 1'b0;
        n.slv.wr    = 1'b0;
        n.reg_rdata = 32'h0;
        n.step      = ~s.step;

        // Identity straps are caught once, in the first cycle after release
        if (!s.keep_cap) begin
            n.keep_cap = 1'b1;
            n.keep_en  = proc_identity_pins[2:1] == epb_pkg::ID_KEEP_HI;
        end

        // Configuration writes; the clear of miss loses to a new miss below
        if (reg_wr && reg_addr == epb_pkg::REG_CFG) begin
            n.ipack    = reg_wdata[epb_pkg::CFG_IPACK_LSB +: 2];
            n.sync     = reg_wdata[epb_pkg::CFG_SYNC_BIT];
            n.link0_en = reg_wdata[epb_pkg::CFG_LINK0_BIT];
            n.link1_en = reg_wdata[epb_pkg::CFG_LINK1_BIT];
            n.half     = reg_wdata[epb_pkg::CFG_HALF_BIT];
            n.sdmap    = reg_wdata[epb_pkg::CFG_SDMAP_LSB +: epb_pkg::NBANK];
        end
        if (reg_wr && reg_addr == epb_pkg::REG_STAT && reg_wdata[epb_pkg::STAT_MISS_BIT]) begin
            n.miss = 1'b0;
        end

        // Read data appear only in the cycle after the strobe
        if (reg_rd) begin
            unique case (reg_addr)
                epb_pkg::REG_CFG:   n.reg_rdata = {20'h0, s.sdmap, 2'b00, s.half,
                                                   s.link1_en, s.link0_en, s.sync, s.ipack};
                epb_pkg::REG_STAT:  n.reg_rdata = {20'h0, s.ms_seen, 2'b00, s.st,
                                                   s.keep_en, 1'b0, s.busy, s.miss};
                epb_pkg::REG_SADDR: n.reg_rdata = {8'h0, s.slv.addr};
                default:            n.reg_rdata = 32'h0;
            endcase
        end

        // Master access sequence
        unique case (s.st)
            epb_pkg::EPB_IDLE: begin
                if (take && !dec_hit) begin
                    n.miss = 1'b1;
                    n.done = 1'b1;
                end else if (take) begin
                    n.st      = epb_pkg::EPB_ACC;
                    n.busy    = 1'b1;
                    n.we      = core_cmd.we;
                    n.wide    = core_cmd.fetch && !core_cmd.we && wide_ok;
                    n.sd      = |(~dec_sel_n & s.sdmap);
                    n.step    = 1'b0;
                    n.addr_o  = dec_off[23:0];
                    n.addr_oe = 1'b1;
                    n.ms_o    = dec_sel_n;
                    n.ms_oe   = 1'b1;
                    n.rd_o    = core_cmd.we;
                    n.wr_o    = !core_cmd.we;
                    n.strb_oe = 1'b1;
                    n.wd      = core_cmd.wdata;
                    n.dat_oe  = core_cmd.we;
                end else if (!bus_master) begin
                    n.addr_oe = 1'b0;
                    n.ms_oe   = 1'b0;
                    n.strb_oe = 1'b0;
                    n.ms_o    = 4'hf;
                end
            end
            epb_pkg::EPB_ACC: begin
                // Low acknowledge holds the access open
                if (finish) begin
                    n.st     = epb_pkg::EPB_TURN;
                    n.rd_o   = 1'b1;
                    n.wr_o   = 1'b1;
                    n.dat_oe = 1'b0;
                    n.done   = 1'b1;
                    n.busy   = 1'b0;
                    if (!s.we) begin
                        n.rdata = {ext_data_bus_upper_i,
                                   s.wide ? ext_data_lane_mid_i : 8'h0,
                                   s.wide ? ext_data_lane_low_i : 8'h0};
                    end
                    // Synchronous selects drop; asynchronous ones follow the address
                    if (s.sync) begin
                        n.ms_o = 4'hf;
                    end
                end
            end
            epb_pkg::EPB_TURN: begin
                n.st = epb_pkg::EPB_IDLE;
            end
            default: begin
                n.st = epb_pkg::EPB_IDLE;
            end
        endcase

        // Slave side: the current master drives address and strobes
        if (!bus_master) begin
            n.ms_seen  = bank_select_n_i;
            n.slv_rd_q = !rd_n_i;
            n.slv_wr_q = !wr_n_i;
            // A strobe pair that breaks the exclusion is ignored outright
            if (!wr_n_i && !s.slv_wr_q && rd_n_i) begin
                if (iop_hit) begin
                    n.slv.wr    = 1'b1;
                    n.slv.addr  = ext_addr_bus_i;
                    n.slv.wdata = ext_data_bus_upper_i;
                end else begin
                    n.miss = 1'b1;
                end
            end
            if (!rd_n_i && !s.slv_rd_q && wr_n_i) begin
                if (iop_hit) begin
                    n.slv.rd   = 1'b1;
                    n.slv.addr = ext_addr_bus_i;
                end else begin
                    n.miss = 1'b1;
                end
            end
            // Drive read data for as long as the reader holds its strobe
            n.dat_oe = !rd_n_i && wr_n_i && iop_hit;
            n.wide   = 1'b0;
            n.wd     = {iop_rdata, 16'h0};
        end

        // Shared lanes: link ports own them when enabled
        n.l0_din = ext_data_lane_low_i;
        n.l1_din = ext_data_lane_mid_i;
        if (s.link1_en) begin
            n.mid_o  = second_link_dout;
            n.mid_oe = second_link_doe;
        end else begin
            n.mid_o  = n.wd[15:8];
            n.mid_oe = n.dat_oe && bus_master;
        end
        if (s.link0_en) begin
            n.low_o  = first_link_dout;
            n.low_oe = first_link_doe;
        end else begin
            n.low_o  = n.wd[7:0];
            n.low_oe = n.dat_oe && bus_master;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_sn) begin
        if (!rst_sn) begin
            s <= epb_pkg::ST_RST;
        end else begin
            s <= n;
        end
    end

    // ****************************************************************
    // Outputs, all straight from the state register
    // ****************************************************************
    assign reg_rdata             = s.reg_rdata;
    assign core_busy             = s.busy;
    assign core_done             = s.done;
    assign core_rdata            = s.rdata;
    assign io_processor_regs     = s.slv;
    assign first_link_data       = s.l0_din;
    assign second_link_data      = s.l1_din;
    assign keeper_en             = s.keep_en;
    assign ext_addr_bus_o        = s.addr_o;
    assign ext_addr_bus_oe       = s.addr_oe;
    assign ext_data_bus_upper_o  = s.wd[47:16];
    assign ext_data_bus_upper_oe = s.dat_oe;
    assign ext_data_lane_mid_o   = s.mid_o;
    assign ext_data_lane_mid_oe  = s.mid_oe;
    assign ext_data_lane_low_o   = s.low_o;
    assign ext_data_lane_low_oe  = s.low_oe;
    assign bank_select_n_o       = s.ms_o;
    assign bank_select_n_oe      = s.ms_oe;
    assign rd_n_o                = s.rd_o;
    assign rd_n_oe               = s.strb_oe;
    assign wr_n_o                = s.wr_o;
    assign wr_n_oe               = s.strb_oe;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sn);

    strobe_excl_a: assert property (s.strb_oe |-> (s.rd_o || s.wr_o))
        else $error("read and write strobes low together");
    one_select_a: assert property (s.ms_oe |-> $countones(~s.ms_o) <= 1)
        else $error("more than one bank select asserted");
    take_drive_a: assert property (take && dec_hit |=> s.addr_oe && s.ms_oe
                                   && s.addr_o == $past(dec_off[23:0]))
        else $error("address not driven after a taken request");
    read_strobe_a: assert property (take && dec_hit && !core_cmd.we
                                    |=> !s.rd_o && s.wr_o && s.strb_oe)
        else $error("read strobe missing on master read");
    write_strobe_a: assert property (take && dec_hit && core_cmd.we
                                     |=> !s.wr_o && s.rd_o && s.dat_oe)
        else $error("write strobe missing on master write");
    wait_state_a: assert property (s.st == epb_pkg::EPB_ACC && !ack_i
                                   |=> s.st == epb_pkg::EPB_ACC && !s.done)
        else $error("access finished while acknowledge low");
    sync_release_a: assert property (finish && s.sync |=> s.ms_o == 4'hf ##1 s.st == epb_pkg::EPB_IDLE)
        else $error("synchronous select not released after acknowledge");
    async_select_a: assert property (finish && !s.sync |=> s.ms_o == $past(s.ms_o))
        else $error("asynchronous select moved without the address");
    wide_fetch_a: assert property (finish && !s.we && s.wide
                                   |=> s.rdata[15:0] == {$past(ext_data_lane_mid_i),
                                                         $past(ext_data_lane_low_i)})
        else $error("wide fetch lost the low lanes");
    lane_guard_a: assert property (take && (s.link0_en || s.link1_en) |=> !s.wide)
        else $error("link-owned lane used for a wide fetch");
    slave_write_a: assert property (!bus_master && !wr_n_i && rd_n_i && !s.slv_wr_q
                                    && iop_hit |=> s.slv.wr && s.slv.addr == $past(ext_addr_bus_i))
        else $error("slave write not decoded");

endmodule : epb_top

/* File: epb_top_tb.sv */
// Self-checking bench of the external port bus interface
`timescale 1ns/1ps
module epb_top_tb;
    logic        clk = 1'b0, rstn = 1'b0, rw = 1'b0, rr = 1'b0, bm = 1'b1, req = 1'b0;
    logic        swr = 1'b1, lk = 1'b0, done, keep, ack, a_oe, u_oe, m_oe, l_oe, ms_oe;
    logic        rd_i, rd_o, rd_oe, wr_i, wr_o, wr_oe, srd = 1'b1, busy;
    logic [1:0]  waits = 2'h0;
    logic [2:0]  ids = 3'h1;
    logic [3:0]  ms_i, ms_o;
    logic [7:0]  ra = 8'h00, m_i, m_o, l_i, l_o, l0d, l1d;
    logic [23:0] sa = 24'h0, a_i, a_o;
    logic [31:0] rwd = 32'h0, rrd, u_i, u_o;
    logic [47:0] crd, dq;
    epb_pkg::epb_req_t cmd = '0;
    epb_pkg::epb_slv_t slv;
    int          fail_count = 0, n_checks = 0, cyc = 0;
    // Pin levels: whoever enables drives, else the far side or the pull-up
    assign a_i  = a_oe ? a_o : sa;
    assign u_i  = u_oe ? u_o : (bm ? dq[47:16] : 32'hc0de0001);
    assign m_i  = m_oe ? m_o : dq[15:8];
    assign l_i  = l_oe ? l_o : dq[7:0];
    assign ms_i = ms_oe ? ms_o : 4'hf;
    assign rd_i = rd_oe ? rd_o : srd;
    assign wr_i = wr_oe ? wr_o : swr;
    epb_mem_model mem_u (.clk(clk), .addr(a_o), .rd_n(rd_o), .wr_n(wr_o), .waits(waits),
        .ack(ack), .dq(dq));
    epb_top dut_u (.clk(clk), .rstn(rstn), .reg_addr(ra), .reg_wdata(rwd), .reg_wr(rw),
        .reg_rd(rr), .reg_rdata(rrd), .bus_master(bm), .core_req(req), .core_cmd(cmd),
        .core_busy(busy), .core_done(done), .core_rdata(crd), .io_processor_regs(slv),
        .iop_rdata({8'h00, slv.addr}), .first_link_dout(8'h00), .first_link_doe(1'b0),
        .first_link_data(l0d), .second_link_dout(8'h00), .second_link_doe(1'b0),
        .second_link_data(l1d), .proc_identity_pins(ids), .keeper_en(keep),
        .ext_addr_bus_i(a_i), .ext_addr_bus_o(a_o), .ext_addr_bus_oe(a_oe),
        .ext_data_bus_upper_i(u_i), .ext_data_bus_upper_o(u_o), .ext_data_bus_upper_oe(u_oe),
        .ext_data_lane_mid_i(m_i), .ext_data_lane_mid_o(m_o), .ext_data_lane_mid_oe(m_oe),
        .ext_data_lane_low_i(l_i), .ext_data_lane_low_o(l_o), .ext_data_lane_low_oe(l_oe),
        .bank_select_n_i(ms_i), .bank_select_n_o(ms_o), .bank_select_n_oe(ms_oe),
        .rd_n_i(rd_i), .rd_n_o(rd_o), .rd_n_oe(rd_oe), .wr_n_i(wr_i), .wr_n_o(wr_o),
        .wr_n_oe(wr_oe), .ack_i(ack));
    task automatic chk(input string nm, input logic [47:0] s, e);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic close_out();
        if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    // Register port: one-cycle strobes, read data stand one cycle later
    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        ra <= a;
        rr <= 1'b1;
        @(posedge clk);
        rr <= 1'b0;
        #1;
        chk("reg", rrd, e);
    endtask : rreg
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        ra <= a;
        rwd <= d;
        rw <= 1'b1;
        @(posedge clk);
        rw <= 1'b0;
    endtask : wreg
    // Master access; the idle lead-in clears the turnaround cycle
    task automatic acc(input logic we, f, input logic [27:0] a, input logic [1:0] w,
                       input logic [3:0] ms, input int nc, input logic [47:0] e);
        int n;
        n = 0;
        repeat (2) @(posedge clk);
        req <= 1'b1;
        cmd <= '{we: we, fetch: f, addr: a, wdata: 48'h5a5a0f0f3c3c};
        waits <= w;
        @(posedge clk);
        req <= 1'b0;
        #1;
        chk("ms", ms_o, ms);
        if (ms != 4'hf) chk("addr", a_o, a[23:0]);
        chk("rd_n", rd_o, we || ms == 4'hf);
        chk("wr_n", wr_o, !we || ms == 4'hf);
        chk("busy", busy, ms != 4'hf);
        if (we) chk("wdata", u_o, 32'h5a5a0f0f);
        if (we) chk("low_oe", l_oe, !lk);
        while (!done && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("cycles", 48'(n), 48'(nc));
        if (!we && ms != 4'hf) chk("rdata", crd, e);
        if (!we && ms != 4'hf) chk("link", {l1d, l0d}, a[15:0]);
    endtask : acc
    // Slave access of the register window from another master
    task automatic swr_t(input logic r, input logic [23:0] a, input logic e);
        @(posedge clk);
        sa <= a;
        if (r) srd <= 1'b0;
        else swr <= 1'b0;
        @(posedge clk);
        #1;
        chk("slv_wr", slv.wr, e && !r);
        chk("slv_rd", slv.rd, e && r);
        if (e) chk("slv_addr", slv.addr, a);
        if (e && !r) chk("slv_data", slv.wdata, 32'hc0de0001);
        @(posedge clk);
        swr <= 1'b1;
        srd <= 1'b1;
        #1;
        if (e && r) chk("slv_rdata", {u_oe, u_o}, {9'h100, a});
    endtask : swr_t
    task automatic t_regs();
        wreg(epb_pkg::REG_CFG, 32'h00000f2d);
        rreg(epb_pkg::REG_CFG, 32'h00000f2d);
        rreg(8'h0c, 32'h0);
        chk("keeper", keep, 1'b1);
    endtask : t_regs
    // Bank sizes, wait states, wide fetch, select timing, refused address
    task automatic t_master();
        wreg(epb_pkg::REG_CFG, 32'h0);
        acc(0, 0, 28'h1000010, 2, 4'hd, 3, {32'h5a000010, 16'h0});
        chk("ms_async", ms_o, 4'hd);
        wreg(epb_pkg::REG_CFG, 32'h1);
        acc(0, 1, 28'h0000abc, 0, 4'he, 1, 48'h5a000abc0abc);
        wreg(epb_pkg::REG_CFG, 32'h100);
        acc(0, 0, 28'h3000010, 0, 4'he, 1, {32'h5a000010, 16'h0});
        acc(0, 0, 28'h4000020, 0, 4'hd, 1, {32'h5a000020, 16'h0});
        wreg(epb_pkg::REG_CFG, 32'h120);
        acc(0, 0, 28'h0000010, 0, 4'he, 2, {32'h5a000010, 16'h0});
        lk = 1'b1;
        wreg(epb_pkg::REG_CFG, 32'hc);
        acc(1, 0, 28'h20000ff, 1, 4'hb, 2, 48'h0);
        chk("ms_sync", ms_o, 4'hf);
        wreg(epb_pkg::REG_CFG, 32'h0);
        acc(0, 0, 28'h4000000, 0, 4'hf, 0, 48'h0);
    endtask : t_master
    initial begin
        forever #25 clk = ~clk;
    end
    // Hang guard well above the run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_master();
        bm <= 1'b0;
        wreg(epb_pkg::REG_STAT, 32'h1);
        swr_t(0, 24'h000012, 1'b1);
        rreg(epb_pkg::REG_SADDR, 32'h12);
        swr_t(1, 24'h000034, 1'b1);
        rreg(epb_pkg::REG_STAT, 32'hf08);
        swr_t(0, 24'h000200, 1'b0);
        rreg(epb_pkg::REG_STAT, 32'hf09);
        ids <= 3'h2;
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        chk("keeper", keep, 1'b0);
        close_out();
    end
endmodule : epb_top_tb
